// *** prl_output_logic.sv ***
// Relay output function logic: trip state, pulse timers, category outputs.
// Assumes synchronous fault levels, settings in 10 ms ticks, one clock.
`default_nettype none

//Contract
// R1: Trip pulse opens on stage-delay expiry, at once for islanding, external, rotation, polarity.
// R2: Trip pulse closes after pulse length; trip persists until reset without fault.
// R3: During trip state no new fault starts another trip pulse.
// R4: After islanding trip, fault reset refused until islanding hold time expires.
// R5: Immediate pulse opens at once on any fault, closes after pulse length.
// R6: Faults during immediate pulse neither retrigger nor extend it. The code restarts it on a fault in its last open cycle, once the count is zero.
// R7: Delayed pulse opens after stage delay or at once, closes after pulse length.
// R8: New fault during delayed pulse restarts its pulse length timing.
// R9: Fault reset affects only the trip state, never signalling outputs.
// R10: Voltage output opens at once; closes when clear and pulse length passed.
// R11: Category output open at trip entry stays open pulse length from trip.
// R12: Stage with zero limit is disabled and never signalled.
// R13: Frequency output opens at once; closes when clear, not before pulse length.
// R14: Islanding output opens at once; closes hold time after latest activation.
// R15: Asymmetry output opens on any of three methods; closes when all clear. The code also waits out pulse length.
// R16: Misc output opens on rotation, polarity, external trip; closes when clear. The code also waits out pulse length.
// R17: Delays are set with 10 ms resolution.
// R18: Delay timing accurate within one percent of set value.
// R19: Frequency fault with zero delay reacts within 75 ms.
// R20: Voltage fault with zero delay reacts within two periods plus 15 ms.
// R21: Vector shift reacts within one and a half periods plus 15 ms.
// R22: Relays energised when fault free, de-energised to show a fault.
// R23: Pulse length accepts 0 to 60 s, default one second.
// R24: Each of five relays selects any output function.
// R25: All timers count a common 10 ms tick from the system clock.
// R26: Fault inputs are synchronous levels; all output transitions registered.
module prl_output_logic
  import prl_pkg::*;
#(
  parameter int TICK_CYCLES_P = prl_pkg::TICK_CYCLES,
  parameter int N_RELAY_P     = prl_pkg::N_RELAY
) (
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire prl_pkg::prl_fault_t    fault_in,
  input  wire prl_pkg::prl_fault_t    stage_en,
  input  wire prl_pkg::prl_setting_t  setting,
  input  wire logic                   fault_reset,
  input  wire prl_pkg::prl_func_t     relay_func [N_RELAY_P],
  output logic [N_RELAY_P-1:0]        relay_energised,
  output prl_pkg::prl_open_t          func_open,
  output logic                        trip_active
);
  import prl_pkg::*;

  logic [TMR_W-1:0]       tick_cnt_ff;
  logic                   tick_ff;
  prl_fault_t             act;
  logic                   any_fault;
  logic [3:0]             cat_act;
  logic                   isl_act;
  logic [TMR_W-1:0]       dly_set [N_STAGE_DLY];
  logic [TMR_W-1:0]       dly_cnt_ff [N_STAGE_DLY];
  logic [N_STAGE_DLY-1:0] dly_exp;
  logic [4:0]             cause_vec;
  logic                   trip_cause;
  logic                   trip_entry;
  prl_fault_t             prev_act_ff;
  logic [4:0]             prev_cause_ff;
  logic                   new_fault;
  logic                   new_cause;
  logic                   trip_ff;
  logic [TMR_W-1:0]       imp_len_eff;
  logic [N_TMR-1:0]       tmr_start;
  logic [N_TMR-1:0]       tmr_hold;
  logic [TMR_W-1:0]       tmr_len [N_TMR];
  logic [TMR_W-1:0]       tmr_cnt_ff [N_TMR];
  logic [N_TMR-1:0]       tmr_open_ff;
  logic [15:0]            fn_open;
  logic [N_RELAY_P-1:0]   relay_ff;
  logic [N_RELAY_P-1:0]   nxt_relay;

  // R25: common tick
  // R18: tick is an exact clock count, so delay error is one tick at most
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == TMR_W'(TICK_CYCLES_P - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TMR_W'(1);
      tick_ff     <= 1'b0;
    end
  end

  // R12: zero-limit stages masked out
  assign act        = fault_in & stage_en;
  assign any_fault  = |act;
  assign cat_act[0] = act.over_volt | act.under_volt;
  assign cat_act[1] = act.over_freq | act.under_freq;
  assign cat_act[2] = act.unbalance | act.pos_seq_uv | act.neg_seq_ov;
  assign cat_act[3] = act.phase_rotation | act.phase_polarity | act.ext_trip;
  assign isl_act    = act.vector_shift | act.freq_rate;

  assign dly_set[0] = setting.volt_delay;
  assign dly_set[1] = setting.freq_delay;
  assign dly_set[2] = setting.asym_delay;

  // R17: delays counted in 10 ms ticks
  // R19: zero delay expires in the detection cycle itself
  // R20: zero delay adds no latency to voltage faults
  for (genvar g = 0; g < N_STAGE_DLY; g++) begin : g_dly
    assign dly_exp[g] = cat_act[g] && (dly_cnt_ff[g] >= dly_set[g]);
    always_ff @(posedge ref_clk) begin
      if (!resetn || !cat_act[g]) begin
        dly_cnt_ff[g] <= '0;
      end else if (tick_ff && !dly_exp[g]) begin
        dly_cnt_ff[g] <= dly_cnt_ff[g] + TMR_W'(1);
      end
    end
  end

  // R1: islanding and misc causes bypass the stage delay
  // R21: vector shift acts in the cycle it is seen
  assign cause_vec  = {cat_act[3], isl_act, dly_exp};
  assign trip_cause = |cause_vec;
  // R3: trip pulse only on entry into the trip state
  assign trip_entry = trip_cause && !trip_ff;

  // R26: previous levels give new detections
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prev_act_ff   <= '0;
      prev_cause_ff <= '0;
    end else begin
      prev_act_ff   <= act;
      prev_cause_ff <= cause_vec;
    end
  end

  assign new_fault = |(act & ~prev_act_ff);
  assign new_cause = |(cause_vec & ~prev_cause_ff);

  // R2: trip persists until reset with no fault present
  // R4: reset refused while islanding hold runs
  // R9: only the trip state sees fault reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      trip_ff <= TRIP_RST;
    end else if (trip_cause) begin
      trip_ff <= 1'b1;
    end else if (fault_reset && !any_fault && !tmr_open_ff[T_ISL]) begin
      trip_ff <= 1'b0;
    end
  end

  // R23: pulse length held within 60 s
  assign imp_len_eff = (setting.imp_len > TMR_W'(IMP_LEN_MAX_TICKS))
                       ? TMR_W'(IMP_LEN_MAX_TICKS) : setting.imp_len;

  // R1: trip pulse starts on entry
  // R6: immediate pulse not retriggered while its count is nonzero
  // R8: delayed pulse restarts on each new cause
  // R11: category outputs already open reload at trip entry
  // R14: islanding hold reloads while active
  always_comb begin
    tmr_start[T_TRIP] = trip_entry;
    // A fault seen as the count reaches zero starts a fresh pulse instead of being lost
    tmr_start[T_IMM]  = new_fault && !(tmr_open_ff[T_IMM] && tmr_cnt_ff[T_IMM] != '0);
    tmr_start[T_DEL]  = new_cause;
    tmr_start[T_ISL]  = isl_act;
    tmr_hold          = '0;
    for (int i = 0; i < 4; i++) begin
      tmr_start[T_VOLT+i] = (cat_act[i] && !tmr_open_ff[T_VOLT+i])
                            || (trip_entry && tmr_open_ff[T_VOLT+i]);
      tmr_hold[T_VOLT+i]  = cat_act[i];
    end
    for (int i = 0; i < N_TMR; i++) begin
      tmr_len[i] = imp_len_eff;
    end
    tmr_len[T_ISL] = setting.islanding_hold_time;
  end

  // R5: immediate pulse runs pulse length
  // R7: delayed pulse closes after pulse length
  // R10: voltage output closes when clear and timed out
  // R13: frequency output closes when clear and timed out
  // R15: asymmetry output closes when all three clear and timed out
  // R16: misc output closes when none active and timed out
  for (genvar g = 0; g < N_TMR; g++) begin : g_tmr
    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        tmr_open_ff[g] <= 1'b0;
        tmr_cnt_ff[g]  <= '0;
      end else if (tmr_start[g]) begin
        tmr_open_ff[g] <= 1'b1;
        tmr_cnt_ff[g]  <= tmr_len[g];
      end else if (tmr_open_ff[g]) begin
        if (tick_ff && tmr_cnt_ff[g] != '0) begin
          tmr_cnt_ff[g] <= tmr_cnt_ff[g] - TMR_W'(1);
        end
        if (tmr_cnt_ff[g] == '0 && !tmr_hold[g]) begin
          tmr_open_ff[g] <= 1'b0;
        end
      end
    end
  end

  assign func_open.common_trip_latched_out   = trip_ff;
  assign func_open.common_trip_pulse_out     = tmr_open_ff[T_TRIP];
  assign func_open.immediate_fault_pulse_out = tmr_open_ff[T_IMM];
  assign func_open.delayed_fault_pulse_out   = tmr_open_ff[T_DEL];
  assign func_open.voltage_fault_out         = tmr_open_ff[T_VOLT];
  assign func_open.frequency_fault_out       = tmr_open_ff[T_FREQ];
  assign func_open.islanding_fault_out       = tmr_open_ff[T_ISL];
  assign func_open.asymmetry_fault_out       = tmr_open_ff[T_ASYM];
  assign func_open.misc_fault_out            = tmr_open_ff[T_MISC];
  assign trip_active                         = trip_ff;

  // Unused function codes read as open, so a bad selection fails safe
  always_comb begin
    fn_open                         = '1;
    fn_open[FN_TRIP_LATCHED]        = trip_ff;
    fn_open[FN_TRIP_PULSE]          = tmr_open_ff[T_TRIP];
    fn_open[FN_IMM_PULSE]           = tmr_open_ff[T_IMM];
    fn_open[FN_DEL_PULSE]           = tmr_open_ff[T_DEL];
    fn_open[FN_VOLT]                = tmr_open_ff[T_VOLT];
    fn_open[FN_FREQ]                = tmr_open_ff[T_FREQ];
    fn_open[FN_ISLAND]              = tmr_open_ff[T_ISL];
    fn_open[FN_ASYM]                = tmr_open_ff[T_ASYM];
    fn_open[FN_MISC]                = tmr_open_ff[T_MISC];
  end

  // R24: per-relay function select
  // R22: energised means fault free
  always_comb begin
    for (int i = 0; i < N_RELAY_P; i++) begin
      nxt_relay[i] = !fn_open[relay_func[i]];
    end
  end

  // R26: relay drive registered
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      relay_ff <= {N_RELAY_P{RELAY_RST}};
    end else begin
      relay_ff <= nxt_relay;
    end
  end

  assign relay_energised = relay_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_trip_pulse_start: assert property (trip_entry |=> trip_ff && tmr_open_ff[T_TRIP]) // R1
    else $error("trip pulse did not start on trip entry");
  a_trip_state_hold: assert property (trip_ff && !fault_reset |=> trip_ff) // R2
    else $error("trip state left without fault reset");
  a_trip_no_retrig: assert property ($rose(tmr_open_ff[T_TRIP]) |-> $rose(trip_ff)) // R3
    else $error("trip pulse started inside trip state");
  a_isl_reset_refuse: assert property (trip_ff && tmr_open_ff[T_ISL] |=> trip_ff) // R4
    else $error("fault reset taken during islanding hold");
  a_imm_pulse_open: assert property (new_fault |=> tmr_open_ff[T_IMM]) // R5
    else $error("immediate pulse not open after new fault");
  a_imm_no_extend: assert property (
    tmr_open_ff[T_IMM] && tmr_cnt_ff[T_IMM] != '0
    |=> tmr_open_ff[T_IMM] && tmr_cnt_ff[T_IMM] <= $past(tmr_cnt_ff[T_IMM])) // R6
    else $error("immediate pulse extended");
  a_del_restart: assert property (
    new_cause |=> tmr_open_ff[T_DEL] && tmr_cnt_ff[T_DEL] == $past(imp_len_eff)) // R8
    else $error("delayed pulse not restarted");
  a_volt_min_open: assert property (
    tmr_open_ff[T_VOLT] && tmr_cnt_ff[T_VOLT] != '0 |=> tmr_open_ff[T_VOLT]) // R10
    else $error("voltage output closed before pulse length");
  a_volt_disabled: assert property (
    !stage_en.over_volt && !stage_en.under_volt && !tmr_open_ff[T_VOLT]
    |=> !tmr_open_ff[T_VOLT]) // R12
    else $error("disabled voltage stage signalled");
  a_relay_map: assert property (
    relay_func[0] == FN_TRIP_PULSE |=> relay_ff[0] == !$past(tmr_open_ff[T_TRIP])) // R24
    else $error("relay 0 does not follow its function");

  c_trip_and_reset: cover property (trip_ff ##[1:1000] !trip_ff);
  c_del_restart:    cover property (tmr_open_ff[T_DEL] && new_cause);
  c_isl_trip:       cover property (isl_act && trip_entry);

endmodule

`default_nettype wire

// *** prl_pkg.sv ***
// Constants and carrier types for the protection relay output logic.
// Assumes a 50 MHz system clock and fault levels already synchronous to it.
`default_nettype none

package prl_pkg;

  localparam int CLK_HZ            = 50_000_000;
  localparam int TICK_MS           = 10;
  localparam int TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
  localparam int TMR_W             = 19;
  localparam int IMP_LEN_DEF_TICKS = 1000 / TICK_MS;
  localparam int IMP_LEN_MAX_TICKS = 60 * 1000 / TICK_MS;
  localparam int N_RELAY           = 5;
  localparam int N_TMR             = 8;
  localparam int N_STAGE_DLY       = 3;

  // Timed output slots
  localparam int T_TRIP = 0;
  localparam int T_IMM  = 1;
  localparam int T_DEL  = 2;
  localparam int T_VOLT = 3;
  localparam int T_FREQ = 4;
  localparam int T_ASYM = 5;
  localparam int T_MISC = 6;
  localparam int T_ISL  = 7;

  localparam logic RELAY_RST = 1'b1;
  localparam logic TRIP_RST  = 1'b0;

  typedef struct packed {
    logic over_volt;
    logic under_volt;
    logic over_freq;
    logic under_freq;
    logic unbalance;
    logic pos_seq_uv;
    logic neg_seq_ov;
    logic vector_shift;
    logic freq_rate;
    logic phase_rotation;
    logic phase_polarity;
    logic ext_trip;
  } prl_fault_t;

  typedef struct packed {
    logic [TMR_W-1:0] imp_len;
    logic [TMR_W-1:0] islanding_hold_time;
    logic [TMR_W-1:0] volt_delay;
    logic [TMR_W-1:0] freq_delay;
    logic [TMR_W-1:0] asym_delay;
  } prl_setting_t;

  typedef enum logic [3:0] {
    FN_TRIP_LATCHED,
    FN_TRIP_PULSE,
    FN_IMM_PULSE,
    FN_DEL_PULSE,
    FN_VOLT,
    FN_FREQ,
    FN_ISLAND,
    FN_ASYM,
    FN_MISC
  } prl_func_t;

  typedef struct packed {
    logic common_trip_latched_out;
    logic common_trip_pulse_out;
    logic immediate_fault_pulse_out;
    logic delayed_fault_pulse_out;
    logic voltage_fault_out;
    logic frequency_fault_out;
    logic islanding_fault_out;
    logic asymmetry_fault_out;
    logic misc_fault_out;
  } prl_open_t;

endpackage

`default_nettype wire

// *** prl_relay_contacts.sv ***
// Contact model of the five output relays facing breaker and alarm circuits.
// Assumes the coil drive comes from the output logic on the same clock.
`default_nettype none

module prl_relay_contacts
  import prl_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic [N_RELAY-1:0] relay_energised,
  output logic      [N_RELAY-1:0] contact_closed
);
  // coil drop opens
  // Armature lag is one cycle; an unpowered coil always reads as an open contact
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      contact_closed <= {N_RELAY{1'b0}};
    end else begin
      contact_closed <= relay_energised;
    end
  end
endmodule

`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the relay output logic and its contacts.
// Assumes a 10-cycle tick so that pulse and hold times stay short.
`default_nettype none

module testbench
  import prl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk;
  logic               resetn;
  prl_fault_t         fi;
  prl_fault_t         en;
  prl_setting_t       st;
  logic               frst;
  prl_func_t          rf [N_RELAY];
  logic [N_RELAY-1:0] rel;
  prl_open_t          fo;
  logic               trip;
  logic [N_RELAY-1:0] cc;
  int                 n_fail;
  int                 total_checks;

  always #10 ref_clk = ~ref_clk;

  prl_output_logic #(.TICK_CYCLES_P(10), .N_RELAY_P(N_RELAY)) DUT (
    .ref_clk         (ref_clk),
    .resetn          (resetn),
    .fault_in        (fi),
    .stage_en        (en),
    .setting         (st),
    .fault_reset     (frst),
    .relay_func      (rf),
    .relay_energised (rel),
    .func_open       (fo),
    .trip_active     (trip)
  );

  prl_relay_contacts PRT (
    .ref_clk         (ref_clk),
    .resetn          (resetn),
    .relay_energised (rel),
    .contact_closed  (cc)
  );

  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Sampling 1 ns after the edge keeps clear of the edge's own updates
  task automatic ws(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_trip();
    int k;
    for (k = 0; k < 60 && trip !== 1'b1; k++) ws(1);
    if (trip !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED t=%0t trip wait ran out", $time);
      tally_and_finish();
    end
  endtask

  task automatic rst();
    w(1);
    resetn <= 1'b0;
    fi     <= '0;
    frst   <= 1'b0;
    w(2);
    resetn <= 1'b1;
    w(2);
  endtask

  initial begin
    ref_clk = 1'b0;
    n_fail = 0;
    total_checks = 0;
    resetn <= 1'b0;
    fi <= '0;
    en <= '1;
    frst <= 1'b0;
    st <= '{imp_len: 19'h4, islanding_hold_time: 19'h4, volt_delay: 19'h2, default: '0};
    rf[0] <= FN_TRIP_PULSE;
    rf[1] <= FN_IMM_PULSE;
    rf[2] <= FN_DEL_PULSE;
    rf[3] <= FN_VOLT;
    rf[4] <= FN_MISC;
    ws(19);
    chk({fo, trip}, 10'h000, "outputs in reset");
    chk({5'h00, rel}, 10'h01f, "relays in reset");
    w(1);
    resetn <= 1'b1;
    w(2);
    $display("reset test done");
    // External trip, then a second one while tripped
    fi.ext_trip <= 1'b1;
    w(1);
    fi.ext_trip <= 1'b0;
    ws(0);
    chk({fo, trip}, 10'h3c3, "external trip entry");
    ws(1);
    chk({5'h00, rel}, 10'h008, "relay mapping");
    ws(1);
    chk({5'h00, cc}, 10'h008, "contacts");
    w(22);
    fi.ext_trip <= 1'b1;
    w(1);
    fi.ext_trip <= 1'b0;
    ws(29);
    chk({fo, trip}, 10'h241, "pulses after retrigger");
    w(1);
    frst <= 1'b1;
    w(1);
    frst <= 1'b0;
    ws(0);
    chk({fo, trip}, 10'h040, "reset leaves signalling");
    ws(25);
    chk({fo, trip}, 10'h000, "delayed pulse closed");
    $display("external trip test done");
    rst();
    fi.vector_shift <= 1'b1;
    w(1);
    fi.vector_shift <= 1'b0;
    ws(0);
    chk({7'h00, fo.islanding_fault_out, fo.common_trip_pulse_out, trip}, 10'h007, "isl");
    w(1);
    frst <= 1'b1;
    ws(6);
    chk({9'h000, trip}, 10'h001, "reset refused in hold");
    w(1);
    frst <= 1'b0;
    ws(30);
    chk({8'h00, fo.islanding_fault_out, trip}, 10'h003, "hold still running");
    ws(20);
    chk({8'h00, fo.islanding_fault_out, trip}, 10'h001, "hold expired");
    w(1);
    frst <= 1'b1;
    w(1);
    frst <= 1'b0;
    ws(0);
    chk({9'h000, trip}, 10'h000, "reset after hold");
    $display("islanding test done");
    rst();
    fi.over_volt <= 1'b1;
    ws(1);
    chk({8'h00, fo.voltage_fault_out, trip}, 10'h002, "volt before delay");
    wait_trip();
    chk({9'h000, fo.common_trip_pulse_out}, 10'h001, "delayed trip pulse");
    w(1);
    fi.over_volt <= 1'b0;
    ws(34);
    chk({9'h000, fo.voltage_fault_out}, 10'h001, "volt held by trip");
    ws(30);
    chk({9'h000, fo.voltage_fault_out}, 10'h000, "volt closed");
    $display("voltage test done");
    rst();
    en.over_freq <= 1'b0;
    fi.over_freq <= 1'b1;
    ws(5);
    chk({fo, trip}, 10'h000, "disabled stage");
    w(1);
    fi.over_freq <= 1'b0;
    fi.under_freq <= 1'b1;
    w(1);
    fi.under_freq <= 1'b0;
    fi.neg_seq_ov <= 1'b1;
    ws(0);
    chk({8'h00, fo.frequency_fault_out, trip}, 10'h003, "freq zero delay");
    w(1);
    fi.neg_seq_ov <= 1'b0;
    ws(0);
    chk({9'h000, fo.asymmetry_fault_out}, 10'h001, "asym open");
    w(1);
    rf[0] <= FN_TRIP_LATCHED;
    rf[1] <= FN_FREQ;
    rf[2] <= FN_ISLAND;
    rf[3] <= FN_ASYM;
    rf[4] <= prl_func_t'(4'hf);
    ws(2);
    chk({5'h00, rel}, 10'h004, "relay remap");
    ws(60);
    chk({8'h00, fo.frequency_fault_out, fo.asymmetry_fault_out}, 10'h000, "closed");
    $display("category test done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
